// ### common/cgs_cfg.svh
// register map, reset values and level constants of the chroma gain path
`ifndef CGS_CFG_SVH
`define CGS_CFG_SVH
`define CGS_A_CTRL 8'h00
`define CGS_A_START 8'h01
`define CGS_A_END 8'h02
`define CGS_A_FLOOR 8'h03
`define CGS_A_FCS 8'h04
`define CGS_A_OGMAX 8'h05
`define CGS_A_RYRATE 8'h06
`define CGS_A_BYRATE 8'h07
`define CGS_A_YRATE 8'h08
`define CGS_A_LUMA_GAIN 8'h09
`define CGS_A_STAT_FACT 8'h0A
`define CGS_A_STAT_PIX 8'h0B
`define CGS_QPAGE 4'h1
`define CGS_CTRL_CSEN 0
`define CGS_CTRL_QSEL 1
`define CGS_CTRL_OGEN 2
`define CGS_CTRL_HOLD 3
`define CGS_FCS_ALV 0
`define CGS_FCS_ATH 2
`define CGS_FCS_LLV 4
`define CGS_FCS_LTH 6
`define CGS_RST_CTRL 8'h01
`define CGS_RST_START 8'hA0
`define CGS_RST_END 8'hD0
`define CGS_RST_FLOOR 8'h8A
`define CGS_RST_FCS 8'h00
`define CGS_RST_OGMAX 8'hFF
`define CGS_RST_RATE 8'hFF
`define CGS_RST_GAIN 8'h80
`define CGS_RST_HUE 8'h00
`define CGS_FULL 8'hFF
`define CGS_UNITY_SH 7
`define CGS_PCT_FULL 100
`define CGS_VTH0_PCT 25
`define CGS_VTH1_PCT 44
`define CGS_VTH2_PCT 63
`define CGS_VTH3_PCT 81
`define CGS_LTH0_PCT 75
`define CGS_LTH1_PCT 81
`define CGS_LTH2_PCT 88
`define CGS_LTH3_PCT 94
`endif

// ### common/cgs_pkg.sv
// types shared by the chroma gain path
package cgs_pkg;
   typedef struct packed {
      logic [7:0] y;
      logic signed [7:0] ry;
      logic signed [7:0] by;
   } cgs_pix_t;
   typedef enum logic [1:0] {
      CGS_Q1 = 2'b00,
      CGS_Q2 = 2'b01,
      CGS_Q3 = 2'b10,
      CGS_Q4 = 2'b11
   } cgs_quad_t;
   typedef enum logic [1:0] {
      CGS_AT_NONE = 2'b00,
      CGS_AT_HALF = 2'b01,
      CGS_AT_QTR = 2'b10,
      CGS_AT_ALL = 2'b11
   } cgs_atten_t;
   typedef struct packed {
      logic [7:0] ry_gain;
      logic [7:0] by_gain;
      logic signed [7:0] ry_hue;
      logic signed [7:0] by_hue;
   } cgs_coef_t;
endpackage

// ### core/cgs_scale.sv
// saturating a * b / 255 scaler
module cgs_scale #(
   parameter int W = 8
) (
   input wire logic [W-1:0] a,
   input wire logic [2*W-1:0] b,
   output logic [W-1:0] y
);
   logic [3*W-1:0] prod;
   logic [3*W-1:0] quot;
   logic [3*W-1:0] full;

   if (W < 2) begin : g_chk
      $error("cgs_scale: width too small");
   end

   assign prod = a * b;
   assign full = {{(2*W){1'b0}}, {W{1'b1}}};
   assign quot = prod / full;
   assign y = (quot > full) ? {W{1'b1}} : quot[W-1:0];
endmodule

// ### core/cgs_mac.sv
// unsigned gain plus hue cross term, unity gain at 2^SH, saturated
module cgs_mac #(
   parameter int W = 8,
   parameter int SH = 7
) (
   input wire logic signed [W-1:0] a,
   input wire logic [W-1:0] g,
   input wire logic signed [W-1:0] c,
   input wire logic signed [W-1:0] h,
   output logic signed [W-1:0] y
);
   logic signed [2*W+1:0] acc;
   logic signed [2*W+1:0] sh;
   logic signed [2*W+1:0] hi;
   logic signed [2*W+1:0] lo;

   if (SH >= 2*W || W < 2) begin : g_chk
      $error("cgs_mac: bad shift or width");
   end

   assign acc = a * $signed({1'b0, g}) + c * h;
   assign sh = acc >>> SH;
   assign hi = (2*W+2)'(2**(W-1) - 1);
   assign lo = -(2*W+2)'(2**(W-1));
   assign y = (sh > hi) ? hi[W-1:0] : ((sh < lo) ? lo[W-1:0] : sh[W-1:0]);
endmodule

// ### core/cgs_top.sv
// chroma gain, suppress, quadrant hue/gain and false-colour path
// Function
// - agc count reduces both chroma gains when enabled
// - suppress enable bit, resets to on
// - start/end counts 8-bit, reset A0/D0
// - floor 00 zeroes both chroma gains, FF none, reset 8A
// - quadrant select: common or per-quadrant hue/gain
// - sixteen quadrant values, quadrant one serves common
// - hold bit freezes controller during quadrant edits
// - attenuate chroma on luma or aperture over threshold
// - amount codes: none, 50, 75, 100 percent
// - aperture threshold codes 25/44/63/81 percent
// - luma threshold codes 75/81/88/94 percent
// - both detected with codes 1 and 2: full
// - both amount fields reset to zero
// - gain = setting * maximum * rate / 255
// - output gain enable; off ignores maximum, rates
// - output gain maximum spans x0 to xFF
// - rates capped at the output gain maximum
// - output gain scales all four quadrants' gains
`include "cgs_cfg.svh"
module cgs_top
   import cgs_pkg::*;
#(
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] agc_gain_count,
   input wire logic in_valid,
   input wire cgs_pix_t in_pix,
   input wire logic [7:0] in_vap_level,
   output logic out_valid,
   output cgs_pix_t out_pix
);
   if (DW != 8) begin : g_chk
      $error("cgs_top: only 8-bit data supported");
   end

   function automatic logic [7:0] pct_level(input int pct);
      int v;
      v = pct * 255 / `CGS_PCT_FULL;
      return 8'(v);
   endfunction

   // ---------------- register file ----------------
   logic [7:0] ctrl_r, start_r, end_r, floor_r, fcs_r;
   logic [7:0] ogmax_r, ryrate_r, byrate_r, yrate_r, luma_gain_r;
   logic [7:0] quad_r [16];
   logic [7:0] rdata_r;

   wire wr_ctrl = reg_we && (reg_addr == `CGS_A_CTRL);
   wire wr_start = reg_we && (reg_addr == `CGS_A_START);
   wire wr_end = reg_we && (reg_addr == `CGS_A_END);
   wire wr_floor = reg_we && (reg_addr == `CGS_A_FLOOR);
   wire wr_fcs = reg_we && (reg_addr == `CGS_A_FCS);
   wire wr_ogmax = reg_we && (reg_addr == `CGS_A_OGMAX);
   wire wr_ryrate = reg_we && (reg_addr == `CGS_A_RYRATE);
   wire wr_byrate = reg_we && (reg_addr == `CGS_A_BYRATE);
   wire wr_yrate = reg_we && (reg_addr == `CGS_A_YRATE);
   wire wr_luma_gain = reg_we && (reg_addr == `CGS_A_LUMA_GAIN);
   wire quad_hit = (reg_addr[7:4] == `CGS_QPAGE);
   wire wr_quad = reg_we && quad_hit;
   wire [3:0] quad_idx = reg_addr[3:0];

   wire csen = ctrl_r[`CGS_CTRL_CSEN];
   wire qsel = ctrl_r[`CGS_CTRL_QSEL];
   wire ogen = ctrl_r[`CGS_CTRL_OGEN];
   wire hold = ctrl_r[`CGS_CTRL_HOLD];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `CGS_RST_CTRL;
         start_r <= `CGS_RST_START;
         end_r <= `CGS_RST_END;
         floor_r <= `CGS_RST_FLOOR;
         fcs_r <= `CGS_RST_FCS;
         ogmax_r <= `CGS_RST_OGMAX;
         ryrate_r <= `CGS_RST_RATE;
         byrate_r <= `CGS_RST_RATE;
         yrate_r <= `CGS_RST_RATE;
         luma_gain_r <= `CGS_RST_GAIN;
      end else begin
         if (wr_ctrl) ctrl_r <= reg_wdata;
         if (wr_start) start_r <= reg_wdata;
         if (wr_end) end_r <= reg_wdata;
         if (wr_floor) floor_r <= reg_wdata;
         if (wr_fcs) fcs_r <= reg_wdata;
         if (wr_ogmax) ogmax_r <= reg_wdata;
         if (wr_ryrate) ryrate_r <= reg_wdata;
         if (wr_byrate) byrate_r <= reg_wdata;
         if (wr_yrate) yrate_r <= reg_wdata;
         if (wr_luma_gain) luma_gain_r <= reg_wdata;
      end
   end

   // quadrant values: index 4*q + {ry gain, by gain, ry hue, by hue}
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 16; i++) begin
            quad_r[i] <= (i[1] == 1'b0) ? `CGS_RST_GAIN : `CGS_RST_HUE;
         end
      end else if (wr_quad) begin
         quad_r[quad_idx] <= reg_wdata;
      end
   end

   // ---------------- held controller state ----------------
   logic [7:0] supp_factor_r;
   logic [7:0] supp_nxt;
   cgs_coef_t coef_act_r [4];
   logic [7:0] span, above, drop_range, ramp_drop;
   logic [15:0] drop_prod;

   assign span = end_r - start_r;
   assign above = agc_gain_count - start_r;
   assign drop_range = `CGS_FULL - floor_r;
   assign drop_prod = drop_range * above;
   // end at or below start is undefined by contract; treat as a step
   assign ramp_drop = (span == 8'h00) ? drop_range : 8'(drop_prod / {8'h00, span});
   assign supp_nxt = !csen ? `CGS_FULL :
                     (agc_gain_count < start_r) ? `CGS_FULL :
                     (agc_gain_count >= end_r) ? floor_r :
                     `CGS_FULL - ramp_drop;

   // frozen while the hold bit is set so edits land atomically
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         supp_factor_r <= `CGS_FULL;
         for (int q = 0; q < 4; q++) begin
            coef_act_r[q] <= {`CGS_RST_GAIN, `CGS_RST_GAIN, `CGS_RST_HUE, `CGS_RST_HUE};
         end
      end else if (!hold) begin
         supp_factor_r <= supp_nxt;
         for (int q = 0; q < 4; q++) begin
            coef_act_r[q] <= {quad_r[4*q], quad_r[4*q+1], quad_r[4*q+2], quad_r[4*q+3]};
         end
      end
   end

   // ---------------- output gain multipliers ----------------
   logic [7:0] ryrate_eff, byrate_eff, yrate_eff;
   logic [15:0] ry_mul, by_mul, y_mul;
   logic [7:0] og_ry [4];
   logic [7:0] og_by [4];
   logic [7:0] og_y;
   logic [7:0] gain_ry [4];
   logic [7:0] gain_by [4];
   logic [7:0] gain_y;

   assign ryrate_eff = (ryrate_r > ogmax_r) ? ogmax_r : ryrate_r;
   assign byrate_eff = (byrate_r > ogmax_r) ? ogmax_r : byrate_r;
   assign yrate_eff = (yrate_r > ogmax_r) ? ogmax_r : yrate_r;
   assign ry_mul = ogmax_r * ryrate_eff;
   assign by_mul = ogmax_r * byrate_eff;
   assign y_mul = ogmax_r * yrate_eff;

   for (genvar q = 0; q < 4; q++) begin : g_quad
      cgs_scale #(.W(8)) u_ry (
         .a(coef_act_r[q].ry_gain),
         .b(ry_mul),
         .y(og_ry[q])
      );
      cgs_scale #(.W(8)) u_by (
         .a(coef_act_r[q].by_gain),
         .b(by_mul),
         .y(og_by[q])
      );
      assign gain_ry[q] = ogen ? og_ry[q] : coef_act_r[q].ry_gain;
      assign gain_by[q] = ogen ? og_by[q] : coef_act_r[q].by_gain;
   end

   cgs_scale #(.W(8)) u_y (
      .a(luma_gain_r),
      .b(y_mul),
      .y(og_y)
   );
   assign gain_y = ogen ? og_y : luma_gain_r;

   // ---------------- stage 1: quadrant pick ----------------
   cgs_quad_t q_in;
   cgs_quad_t q_use;
   cgs_quad_t q1_r;
   cgs_pix_t p1_r;
   logic [7:0] vap1_r;
   logic v1_r;

   assign q_in = !in_pix.ry[7] ? (!in_pix.by[7] ? CGS_Q1 : CGS_Q2) :
                                 (in_pix.by[7] ? CGS_Q3 : CGS_Q4);
   assign q_use = qsel ? q_in : CGS_Q1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         v1_r <= 1'b0;
         p1_r <= '0;
         vap1_r <= 8'h00;
         q1_r <= CGS_Q1;
      end else begin
         v1_r <= in_valid;
         if (in_valid) begin
            p1_r <= in_pix;
            vap1_r <= in_vap_level;
            q1_r <= q_use;
         end
      end
   end

   // ---------------- stage 2: gain, hue, false colour ----------------
   cgs_coef_t c_sel;
   logic [7:0] sup_ry, sup_by;
   logic signed [7:0] mac_ry, mac_by;
   logic [7:0] vth_lvl, lth_lvl;
   logic vap_det, luma_det, combo12;
   cgs_atten_t a_code, l_code, at_code;
   logic signed [7:0] ry_att, by_att;
   logic [15:0] y_prod;
   logic [15:0] y_sh;
   logic [7:0] y_sat;

   assign c_sel = coef_act_r[q1_r];

   cgs_scale #(.W(8)) u_sup_ry (
      .a(gain_ry[q1_r]),
      .b({8'h00, supp_factor_r}),
      .y(sup_ry)
   );
   cgs_scale #(.W(8)) u_sup_by (
      .a(gain_by[q1_r]),
      .b({8'h00, supp_factor_r}),
      .y(sup_by)
   );

   cgs_mac #(.W(8), .SH(`CGS_UNITY_SH)) u_mac_ry (
      .a(p1_r.ry),
      .g(sup_ry),
      .c(p1_r.by),
      .h(c_sel.ry_hue),
      .y(mac_ry)
   );
   cgs_mac #(.W(8), .SH(`CGS_UNITY_SH)) u_mac_by (
      .a(p1_r.by),
      .g(sup_by),
      .c(p1_r.ry),
      .h(c_sel.by_hue),
      .y(mac_by)
   );

   assign vth_lvl = (fcs_r[`CGS_FCS_ATH +: 2] == 2'd0) ? pct_level(`CGS_VTH0_PCT) :
                    (fcs_r[`CGS_FCS_ATH +: 2] == 2'd1) ? pct_level(`CGS_VTH1_PCT) :
                    (fcs_r[`CGS_FCS_ATH +: 2] == 2'd2) ? pct_level(`CGS_VTH2_PCT) :
                    pct_level(`CGS_VTH3_PCT);
   assign lth_lvl = (fcs_r[`CGS_FCS_LTH +: 2] == 2'd0) ? pct_level(`CGS_LTH0_PCT) :
                    (fcs_r[`CGS_FCS_LTH +: 2] == 2'd1) ? pct_level(`CGS_LTH1_PCT) :
                    (fcs_r[`CGS_FCS_LTH +: 2] == 2'd2) ? pct_level(`CGS_LTH2_PCT) :
                    pct_level(`CGS_LTH3_PCT);
   assign vap_det = vap1_r > vth_lvl;
   assign luma_det = p1_r.y > lth_lvl;
   assign a_code = cgs_atten_t'(vap_det ? fcs_r[`CGS_FCS_ALV +: 2] : 2'd0);
   assign l_code = cgs_atten_t'(luma_det ? fcs_r[`CGS_FCS_LLV +: 2] : 2'd0);
   assign combo12 = ((a_code == CGS_AT_HALF) && (l_code == CGS_AT_QTR)) ||
                    ((a_code == CGS_AT_QTR) && (l_code == CGS_AT_HALF));
   assign at_code = combo12 ? CGS_AT_ALL :
                    ((a_code > l_code) ? a_code : l_code);

   always_comb begin
      case (at_code)
         CGS_AT_NONE: begin
            ry_att = mac_ry;
            by_att = mac_by;
         end
         CGS_AT_HALF: begin
            ry_att = mac_ry >>> 1;
            by_att = mac_by >>> 1;
         end
         CGS_AT_QTR: begin
            ry_att = mac_ry >>> 2;
            by_att = mac_by >>> 2;
         end
         default: begin
            ry_att = 8'sh00;
            by_att = 8'sh00;
         end
      endcase
   end

   assign y_prod = p1_r.y * gain_y;
   assign y_sh = y_prod >> `CGS_UNITY_SH;
   assign y_sat = (y_sh > {8'h00, `CGS_FULL}) ? `CGS_FULL : y_sh[7:0];

   logic [1:0] det_r;
   cgs_quad_t qlast_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_valid <= 1'b0;
         out_pix <= '0;
         det_r <= 2'b00;
         qlast_r <= CGS_Q1;
      end else begin
         out_valid <= v1_r;
         if (v1_r) begin
            out_pix <= '{y: y_sat, ry: ry_att, by: by_att};
            det_r <= {vap_det, luma_det};
            qlast_r <= q1_r;
         end
      end
   end

   // ---------------- read port ----------------
   wire [7:0] rd_mux =
      (reg_addr == `CGS_A_CTRL) ? ctrl_r :
      (reg_addr == `CGS_A_START) ? start_r :
      (reg_addr == `CGS_A_END) ? end_r :
      (reg_addr == `CGS_A_FLOOR) ? floor_r :
      (reg_addr == `CGS_A_FCS) ? fcs_r :
      (reg_addr == `CGS_A_OGMAX) ? ogmax_r :
      (reg_addr == `CGS_A_RYRATE) ? ryrate_r :
      (reg_addr == `CGS_A_BYRATE) ? byrate_r :
      (reg_addr == `CGS_A_YRATE) ? yrate_r :
      (reg_addr == `CGS_A_LUMA_GAIN) ? luma_gain_r :
      (reg_addr == `CGS_A_STAT_FACT) ? supp_factor_r :
      (reg_addr == `CGS_A_STAT_PIX) ? {4'h0, det_r, qlast_r} :
      quad_hit ? quad_r[quad_idx] : 8'h00;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= reg_re ? rd_mux : 8'h00;
      end
   end
   assign reg_rdata = rdata_r;

   // ---------------- checks ----------------
   supp_below_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!hold && csen && agc_gain_count < start_r) |=> (supp_factor_r == `CGS_FULL))
      else $error("suppress active below start count");
   supp_floor_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!hold && csen && agc_gain_count >= end_r) |=> (supp_factor_r == $past(floor_r)))
      else $error("suppress not at floor past end count");
   supp_off_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!hold && !csen) |=> (supp_factor_r == `CGS_FULL))
      else $error("suppress acts while disabled");
   hold_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
      hold |=> ($stable(supp_factor_r) && $stable(coef_act_r[1])))
      else $error("controller state moved during hold");
   quad_sign_a: assert property (@(posedge clk) disable iff (!arst_n)
      (in_valid && qsel && in_pix.ry[7] && in_pix.by[7]) |=> (q1_r == CGS_Q3))
      else $error("wrong quadrant for negative pair");
   quad_common_a: assert property (@(posedge clk) disable iff (!arst_n)
      (in_valid && !qsel) |=> (q1_r == CGS_Q1))
      else $error("common mode used other quadrant set");
   fc_full_a: assert property (@(posedge clk) disable iff (!arst_n)
      (v1_r && vap_det && luma_det && combo12) |=> (out_pix.ry == 8'sh00 && out_pix.by == 8'sh00))
      else $error("combined false colour not fully suppressed");
   og_off_a: assert property (@(posedge clk) disable iff (!arst_n)
      !ogen |-> (gain_ry[2] == coef_act_r[2].ry_gain && gain_y == luma_gain_r))
      else $error("output gain applied while disabled");
   rate_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
      (ogen && ryrate_r > ogmax_r) |-> (ry_mul == ogmax_r * ogmax_r))
      else $error("rate exceeds output gain maximum");
   pipe_lat_a: assert property (@(posedge clk) disable iff (!arst_n)
      in_valid |-> ##2 out_valid)
      else $error("pixel lost in pipeline");
endmodule

// ### testbench/cgs_src.sv
// upstream colour-difference source model feeding the chroma gain path
module cgs_src
   import cgs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req_valid,
   input wire cgs_pix_t req_pix,
   input wire logic [7:0] req_vap,
   output logic in_valid,
   output cgs_pix_t in_pix,
   output logic [7:0] in_vap_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle cycles carry inverted data so a stale pixel never passes for a fresh one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_valid <= 1'b0;
         in_pix <= '0;
         in_vap_level <= 8'h00;
      end else begin
         in_valid <= req_valid;
         in_pix <= req_valid ? req_pix : ~in_pix;
         in_vap_level <= req_valid ? req_vap : ~in_vap_level;
      end
   end
endmodule

// ### testbench/cgs_top_tb_top.sv
// self-checking bench of the chroma gain path
`include "cgs_cfg.svh"
module cgs_top_tb_top
   import cgs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, reg_we, reg_re, out_valid, req_valid, in_valid, re_d;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, agc, req_vap, in_vap_level;
   cgs_pix_t req_pix, in_pix, out_pix;
   logic [7:0] sh [0:31];
   logic [7:0] qa [0:15];
   logic [31:0] seed = 32'hACD5;
   cgs_pix_t pq[$];
   logic [7:0] rq[$];
   logic [7:0] ag [7] = '{8'h3F, 8'h40, 8'h41, 8'h60, 8'h7F, 8'h80, 8'hFF};
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   cgs_src u_src (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_pix(req_pix),
      .req_vap(req_vap), .in_valid(in_valid), .in_pix(in_pix), .in_vap_level(in_vap_level));
   cgs_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .agc_gain_count(agc),
      .in_valid(in_valid), .in_pix(in_pix), .in_vap_level(in_vap_level),
      .out_valid(out_valid), .out_pix(out_pix));

   function automatic logic [31:0] rnd();
      seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
      return seed;
   endfunction

   function automatic int clip(int v, int lo, int hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction

   function automatic int gn(int set, int rate);
      int mx;
      mx = sh[5];
      if (!sh[0][2]) return set;
      return clip(set * mx * (rate < mx ? rate : mx) / 255, 0, 255);
   endfunction

   function automatic cgs_pix_t ref_pix(cgs_pix_t p, logic [7:0] vap);
      int f, q, g, ry, by, a, la, va;
      int lt[4] = '{75, 81, 88, 94};
      int vt[4] = '{25, 44, 63, 81};
      cgs_pix_t r;
      f = 255;
      if (sh[0][0] && agc >= sh[1]) begin
         if (agc >= sh[2]) f = sh[3];
         else f = 255 - (255 - sh[3]) * (agc - sh[1]) / (sh[2] - sh[1]);
      end
      q = sh[0][1] ? {p.ry[7], p.ry[7] ^ p.by[7]} : 0;
      g = gn(qa[4*q], sh[6]) * f / 255;
      ry = clip((p.ry * g + p.by * $signed(qa[4*q+2])) >>> 7, -128, 127);
      g = gn(qa[4*q+1], sh[7]) * f / 255;
      by = clip((p.by * g + p.ry * $signed(qa[4*q+3])) >>> 7, -128, 127);
      r.y = 8'(clip((p.y * gn(sh[9], sh[8])) >>> 7, 0, 255));
      la = (p.y > lt[sh[4][7:6]] * 255 / 100) ? sh[4][5:4] : 0;
      va = (vap > vt[sh[4][3:2]] * 255 / 100) ? sh[4][1:0] : 0;
      a = la > va ? la : va;
      if (la * va == 2) a = 3;
      r.ry = (a == 3) ? 8'h00 : 8'(ry >>> a);
      r.by = (a == 3) ? 8'h00 : 8'(by >>> a);
      return r;
   endfunction

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      if (a < 8'h0A || (a >= 8'h10 && a < 8'h20)) sh[a[4:0]] = d;
      // quadrant copy only follows while the controller runs
      if (!sh[0][3]) for (int i = 0; i < 16; i++) qa[i] = sh[16+i];
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge clk);
      reg_re <= 1'b0;
   endtask

   task automatic px(int n);
      cgs_pix_t p;
      logic [7:0] v;
      repeat (n) begin
         @(posedge clk);
         {p, v} = rnd();
         req_valid <= 1'b1;
         req_pix <= p;
         req_vap <= v;
         pq.push_back(ref_pix(p, v));
      end
      @(posedge clk);
      req_valid <= 1'b0;
   endtask

   task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t register read %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_pix(cgs_pix_t got, cgs_pix_t exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t pixel %h want %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (pq.size() + rq.size() != 0) begin
         err_count++;
         $display("BAD %0t results missing at the end", $time);
      end
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) re_d <= reg_re;

   always @(negedge clk) begin
      if (re_d) chk_reg(reg_rdata, rq.pop_front());
      if (out_valid) chk_pix(out_pix, pq.pop_front());
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      arst_n = 1'b0;
      reg_we = 1'b0;
      reg_re = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      agc = 8'h00;
      req_valid = 1'b0;
      req_pix = '0;
      req_vap = 8'h00;
      for (int i = 0; i < 32; i++) sh[i] = (i >= 16 && !i[1]) ? 8'h80 : 8'h00;
      sh[0] = 8'h01;
      sh[1] = 8'hA0;
      sh[2] = 8'hD0;
      sh[3] = 8'h8A;
      for (int i = 5; i < 10; i++) sh[i] = i == 9 ? 8'h80 : 8'hFF;
      for (int i = 0; i < 16; i++) qa[i] = sh[16+i];
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 33; i++)
         if (i != 10 && i != 11) rd(8'(i), (i < 32) ? sh[i] : 8'h00);
      wr(`CGS_A_CTRL, 8'h0A);
      for (int i = 16; i < 32; i++) wr(8'(i), 8'(rnd()));
      for (int i = 16; i < 32; i++) rd(8'(i), sh[i]);
      wr(`CGS_A_CTRL, 8'h02);
      px(64);
      wr(`CGS_A_CTRL, 8'h00);
      px(32);
      wr(`CGS_A_CTRL, 8'h08);
      wr(8'h10, 8'h40);
      px(16);
      wr(`CGS_A_CTRL, 8'h00);
      px(16);
      for (int k = 0; k < 6; k++) begin
         wr(`CGS_A_OGMAX, (k == 0) ? 8'h00 : 8'(rnd()));
         for (int i = 6; i < 9; i++) wr(8'(i), 8'(rnd()));
         wr(`CGS_A_CTRL, k[0] ? 8'h02 : 8'h06);
         px(24);
      end
      wr(`CGS_A_START, 8'h40);
      wr(`CGS_A_END, 8'h80);
      wr(`CGS_A_CTRL, 8'h01);
      for (int f = 0; f < 3; f++) begin
         wr(`CGS_A_FLOOR, (f == 0) ? 8'h00 : (f == 1 ? 8'h8A : 8'hFF));
         foreach (ag[i]) begin
            @(posedge clk);
            agc <= ag[i];
            repeat (3) @(posedge clk);
            px(4);
         end
         wr(`CGS_A_STAT_FACT, 8'h00);
         rd(`CGS_A_STAT_FACT, sh[3]);
      end
      wr(`CGS_A_CTRL, 8'h00);
      px(4);
      @(posedge clk);
      agc <= 8'h00;
      for (int i = 16; i < 20; i++) wr(8'(i), i < 18 ? 8'h80 : 8'h00);
      for (int f = 0; f < 256; f++) begin
         wr(`CGS_A_FCS, 8'(f));
         px(6);
      end
      repeat (6) @(posedge clk);
      print_verdict();
   end
endmodule
